// >>> csi_map.vh
// register map, field positions, reset values and codes of the serial channel
`ifndef CSI_MAP_VH
`define CSI_MAP_VH
// ==============================================================
// register byte offsets
`define OFS_DATA      8'h00
`define OFS_CTRL      8'h04
`define OFS_STAT      8'h08
// ==============================================================
// data register fields
`define DATA_RST      16'h0000
`define DIV_HI        15
`define DIV_LO        9
// ==============================================================
// control register fields
`define CTL_WLEN_HI   1
`define CTL_WLEN_LO   0
`define CTL_DAP       2
`define CTL_CKP       3
`define CTL_LSB       4
`define CTL_CONT      5
`define CTL_RUN       6
`define CTL_PRE_HI    11
`define CTL_PRE_LO    8
`define CTRL_RST      12'h003
// ==============================================================
// status register fields
`define ST_OVF        0
`define ST_BUSY       1
`define ST_BUFFULL    2
`define ST_RXPEND     3
// ==============================================================
// word length codes
`define WLEN_9        2'b01
`define WLEN_7        2'b10
`define WLEN_8        2'b11
// ==============================================================
// bus responses
`define RESP_OKAY     2'b00
`define RESP_SLVERR   2'b10
`endif

// >>> pin_sync.v
// two-flop synchroniser for one pin input
module pin_sync (
    // clock and reset
    input  wire clk,
    input  wire rst,
    input  wire ce,
    // level in and out
    input  wire d,
    output reg  q
);
    reg meta_q;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            q      <= 1'b0;
        end else if (ce) begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule // pin_sync

// >>> mck_prescaler.v
// channel operation clock enable: one tick every 2^sel system clocks
module mck_prescaler (
    // clock and reset
    input  wire       clk,
    input  wire       rst,
    input  wire       ce,
    // selection and tick
    input  wire [3:0] sel,
    output wire       tick
);
    reg  [14:0] cnt_q;
    wire [14:0] mask = ~(15'h7FFF << sel);

    assign tick = ((cnt_q & mask) == mask);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 15'h0000;
        end else if (ce) begin
            cnt_q <= cnt_q + 15'h0001;
        end
    end
endmodule // mck_prescaler

// >>> csi_master.v
// clocked serial master channel with its data/divider register on AXI4-Lite
// Operation
// - 8-bit shift register serialises and deserialises data
// - shift register reached only through data register
// - 16-bit register, bits 15:9 hold divider
// - received word stored; written word transmitted
// - length field picks 7/8/9 bits, right-justified; a 9-bit code here still shifts 8 bits
// - 9-bit length only on first async channel
// - bits above word length read zero after reception
// - word access and low byte alias access
// - reset clears whole data register
// - byte write to low bits clears divider
// - master drives clock, shifts both ways together
// - interrupt: end of transfer or buffer empty
// - only receive overrun is detected and flagged
// - clock rate limits: fclk/2, fclk/4, minimum
//
// Our own choices: the AXI4-Lite slave port and the address map.
`include "csi_map.vh"
module csi_master #(
    parameter FIRST_CLOCKED = 1,
    parameter FIRST_ASYNC   = 0
) (
    // clock, reset, enable
    input  wire        SYS_CLK,
    input  wire        RST,
    input  wire        CE,
    // write address channel
    input  wire [7:0]  AWADDR,
    input  wire        AWVALID,
    output reg         AWREADY,
    // write data channel
    input  wire [31:0] WDATA,
    input  wire [3:0]  WSTRB,
    input  wire        WVALID,
    output reg         WREADY,
    // write response channel
    output reg  [1:0]  BRESP,
    output reg         BVALID,
    input  wire        BREADY,
    // read address channel
    input  wire [7:0]  ARADDR,
    input  wire        ARVALID,
    output reg         ARREADY,
    // read data channel
    output reg  [31:0] RDATA,
    output reg  [1:0]  RRESP,
    output reg         RVALID,
    input  wire        RREADY,
    // serial pins
    input  wire        SI_IN,
    output reg         SCK_OUT,
    output reg         SO_OUT,
    // channel event
    output reg         CLOCKED_CHANNEL_IRQ
);
    // ==============================================================
    // states
    localparam [1:0] ST_IDLE  = 2'b01;
    localparam [1:0] ST_SHIFT = 2'b10;

    reg  [1:0]  state_q;
    reg  [15:0] data_q;
    reg  [11:0] ctrl_q;
    reg         ovf_q;
    reg         buf_full_q;
    reg         rx_pend_q;
    reg  [7:0]  tx_q;
    reg  [7:0]  rx_q;
    reg  [4:0]  edge_q;
    reg  [6:0]  step_q;
    reg         aw_hold_q;
    reg         w_hold_q;
    reg  [7:0]  awaddr_q;
    reg  [31:0] wdata_q;
    reg  [3:0]  wstrb_q;

    wire        si_s;
    wire        mck_tick;

    // ==============================================================
    // pin input and operation clock
    pin_sync u_si_sync (
        .clk (SYS_CLK),
        .rst (RST),
        .ce  (CE),
        .d   (SI_IN),
        .q   (si_s)
    );

    mck_prescaler u_mck (
        .clk  (SYS_CLK),
        .rst  (RST),
        .ce   (CE),
        .sel  (ctrl_q[`CTL_PRE_HI:`CTL_PRE_LO]),
        .tick (mck_tick)
    );

    // ==============================================================
    // control decode
    wire       dap    = ctrl_q[`CTL_DAP];
    wire       ckp    = ctrl_q[`CTL_CKP];
    wire       lsb    = ctrl_q[`CTL_LSB];
    wire       cont   = ctrl_q[`CTL_CONT];
    wire       run    = ctrl_q[`CTL_RUN];
    wire [1:0] wlen   = ctrl_q[`CTL_WLEN_HI:`CTL_WLEN_LO];
    wire       n7     = (wlen == `WLEN_7);
    wire [6:0] div    = data_q[`DIV_HI:`DIV_LO];
    // only the first clocked channel may step every system clock
    wire       fast   = (ctrl_q[`CTL_PRE_HI:`CTL_PRE_LO] == 4'h0) && (div == 7'h00);
    wire [6:0] div_e  = (FIRST_CLOCKED == 0 && fast) ? 7'h01 : div;
    wire [4:0] last_e = (n7 ? 5'd14 : 5'd16) + {3'b000, dap, 1'b0};

    function pick;
        input [7:0] v;
        begin
            pick = lsb ? v[0] : (n7 ? v[6] : v[7]);
        end
    endfunction

    // ==============================================================
    // bus handshakes
    wire       wr_go   = aw_hold_q && w_hold_q && !BVALID;
    wire       wr_data = wr_go && (awaddr_q == `OFS_DATA);
    wire       wr_ctrl = wr_go && (awaddr_q == `OFS_CTRL);
    wire       wr_stat = wr_go && (awaddr_q == `OFS_STAT);
    wire       wr_ok   = wr_data || wr_ctrl || wr_stat;
    wire       rd_go   = ARREADY && ARVALID;
    wire       rd_data = rd_go && (ARADDR == `OFS_DATA);

    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            AWREADY   <= 1'b0;
            WREADY    <= 1'b0;
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            awaddr_q  <= 8'h00;
            wdata_q   <= 32'h00000000;
            wstrb_q   <= 4'h0;
            BVALID    <= 1'b0;
            BRESP     <= `RESP_OKAY;
        end else if (CE) begin
            if (AWREADY && AWVALID) begin
                aw_hold_q <= 1'b1;
                awaddr_q  <= AWADDR;
                AWREADY   <= 1'b0;
            end else if (!aw_hold_q && !BVALID) begin
                AWREADY <= 1'b1;
            end
            if (WREADY && WVALID) begin
                w_hold_q <= 1'b1;
                wdata_q  <= WDATA;
                wstrb_q  <= WSTRB;
                WREADY   <= 1'b0;
            end else if (!w_hold_q && !BVALID) begin
                WREADY <= 1'b1;
            end
            if (wr_go) begin
                aw_hold_q <= 1'b0;
                w_hold_q  <= 1'b0;
                BVALID    <= 1'b1;
                BRESP     <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            end else if (BVALID && BREADY) begin
                BVALID <= 1'b0;
            end
        end
    end

    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b0;
            RDATA   <= 32'h00000000;
            RRESP   <= `RESP_OKAY;
        end else if (CE) begin
            if (rd_go) begin
                ARREADY <= 1'b0;
                RVALID  <= 1'b1;
                RRESP   <= `RESP_OKAY;
                case (ARADDR)
                    `OFS_DATA: RDATA <= {16'h0000, data_q};
                    `OFS_CTRL: RDATA <= {20'h00000, ctrl_q};
                    `OFS_STAT: RDATA <= {28'h0000000, rx_pend_q, buf_full_q,
                                         state_q[1], ovf_q};
                    default: begin
                        RDATA <= 32'h00000000;
                        RRESP <= `RESP_SLVERR;
                    end
                endcase
            end else if (RVALID && RREADY) begin
                RVALID <= 1'b0;
            end else if (!RVALID) begin
                ARREADY <= 1'b1;
            end
        end
    end

    // ==============================================================
    // control register
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            ctrl_q <= `CTRL_RST;
        end else if (CE && wr_ctrl) begin
            if (wstrb_q[0]) begin
                ctrl_q[6:0] <= wdata_q[6:0];
                // a nine-bit request on any other channel falls back to eight
                if (wdata_q[1:0] == `WLEN_9 && FIRST_ASYNC == 0) begin
                    ctrl_q[`CTL_WLEN_HI:`CTL_WLEN_LO] <= `WLEN_8;
                end
            end
            if (wstrb_q[1]) begin
                ctrl_q[11:8] <= wdata_q[11:8];
            end
        end
    end

    // ==============================================================
    // received word, right-justified and zero-filled above the length
    wire [7:0] rx_al  = (lsb && n7) ? {1'b0, rx_q[7:1]} : rx_q;
    wire [8:0] rx_fin = n7 ? {2'b00, rx_al[6:0]} : {1'b0, rx_al};

    // step timing: each half of the serial clock lasts div_e+1 operation ticks
    wire       step_end = mck_tick && (step_q == div_e);
    wire [4:0] e_nx     = edge_q + 5'd1;
    wire       done     = step_end && (e_nx == last_e);
    wire       start    = (state_q == ST_IDLE) && run && buf_full_q;

    // ==============================================================
    // shift engine and data register
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            state_q             <= ST_IDLE;
            data_q              <= `DATA_RST;
            ovf_q               <= 1'b0;
            buf_full_q          <= 1'b0;
            rx_pend_q           <= 1'b0;
            tx_q                <= 8'h00;
            rx_q                <= 8'h00;
            edge_q              <= 5'd0;
            step_q              <= 7'h00;
            SCK_OUT             <= 1'b0;
            SO_OUT              <= 1'b1;
            CLOCKED_CHANNEL_IRQ <= 1'b0;
        end else if (CE) begin
            CLOCKED_CHANNEL_IRQ <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    SCK_OUT <= ckp;
                    step_q  <= 7'h00;
                    if (start) begin
                        // software never touches the shift register itself
                        tx_q       <= data_q[7:0];
                        SO_OUT     <= pick(data_q[7:0]);
                        buf_full_q <= 1'b0;
                        edge_q     <= {4'h0, dap};
                        // without the data lead the first edge comes at once
                        SCK_OUT    <= ~dap ^ ckp;
                        state_q    <= ST_SHIFT;
                        if (cont) begin
                            CLOCKED_CHANNEL_IRQ <= 1'b1;
                        end
                    end
                end
                ST_SHIFT: begin
                    if (!run) begin
                        state_q <= ST_IDLE;
                    end else if (mck_tick) begin
                        step_q <= step_end ? 7'h00 : step_q + 7'h01;
                    end
                    if (run && step_end) begin
                        edge_q  <= e_nx;
                        SCK_OUT <= (done ? 1'b0 : ~e_nx[0]) ^ ckp;
                        if (done) begin
                            state_q <= ST_IDLE;
                            if (!cont) begin
                                CLOCKED_CHANNEL_IRQ <= 1'b1;
                            end
                        end else if (e_nx[0] != dap) begin
                            // sampling edge
                            rx_q <= lsb ? {si_s, rx_q[7:1]} : {rx_q[6:0], si_s};
                        end else begin
                            // shifting edge: next bit goes out
                            tx_q   <= lsb ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
                            SO_OUT <= lsb ? tx_q[1] : (n7 ? tx_q[5] : tx_q[6]);
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase

            // received word lands in the buffer bits; a queued transmit word
            // is never overwritten, so the new word is lost and flagged
            if (done && run) begin
                if (!buf_full_q) begin
                    data_q[8:0] <= rx_fin;
                end
                rx_pend_q <= 1'b1;
            end else if (rd_data) begin
                rx_pend_q <= 1'b0;
            end

            // overrun is the only error; set wins over the clear
            if (done && run && (rx_pend_q || buf_full_q)) begin
                ovf_q <= 1'b1;
            end else if (wr_stat && wstrb_q[0] && wdata_q[`ST_OVF]) begin
                ovf_q <= 1'b0;
            end

            if (wr_data) begin
                if (wstrb_q[0]) begin
                    data_q[7:0] <= wdata_q[7:0];
                    buf_full_q  <= 1'b1;
                end
                if (wstrb_q[1]) begin
                    data_q[15:8] <= wdata_q[15:8];
                end else if (wstrb_q[0]) begin
                    // byte alias write: divider and bit 8 drop to zero
                    data_q[15:8] <= 8'h00;
                end
            end
        end
    end
endmodule // csi_master

// >>> csi_slave_model.sv
// behavioural three-wire serial slave facing the channel master
module csi_slave_model (
    // serial pins
    input  wire        sck,
    input  wire        so,
    output logic       si,
    // framing setup from the bench
    input  wire        en,
    input  wire        ckp,
    input  wire        dap,
    input  wire        lsb,
    input  wire  [3:0] nbits,
    input  wire  [7:0] tx,
    output logic [7:0] rx
);
    timeunit 1ns;
    timeprecision 1ns;
    int  cnt = 0;
    wire r = sck ^ ckp;
    function automatic int idx(int i);
        return lsb ? i : nbits - 1 - i;
    endfunction
    initial si = 1'b0;
    initial rx = 8'h00;
    always @(posedge en) begin
        cnt = 0;
        rx = 8'h00;
        si = tx[idx(0)];
    end
    // the simulator must not settle a released line for us
    always @(negedge en) si = ~si;
    // edges are ignored while disabled: a polarity change at idle is no clock
    always @(r) begin
        if (en) begin
            if (r == dap) begin
                rx[idx(cnt)] = so;
                cnt = cnt + 1;
                if (cnt == nbits) begin
                    cnt = 0;
                    si = tx[idx(0)];
                end
            end else if (cnt != 0) begin
                si = tx[idx(cnt)];
            end
        end
    end
endmodule // csi_slave_model

// >>> csi_master_chk.sv
// port assertions for the clocked serial master channel
`include "csi_map.vh"
module csi_master_chk #(
    parameter FIRST_CLOCKED = 1
) (
    // clock and reset
    input wire        SYS_CLK,
    input wire        RST,
    // register bus
    input wire        AWVALID,
    input wire        AWREADY,
    input wire        WVALID,
    input wire        WREADY,
    input wire [1:0]  BRESP,
    input wire        BVALID,
    input wire        BREADY,
    input wire        ARVALID,
    input wire        ARREADY,
    input wire [31:0] RDATA,
    input wire        RVALID,
    input wire        RREADY,
    // serial side
    input wire        SCK_OUT,
    input wire        SO_OUT,
    input wire        CLOCKED_CHANNEL_IRQ
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);
    // ==========================================================
    // register bus
    // both channels taken at one edge: the response is raised at the edge after
    chk_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
        else $error("write not answered");
    chk_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read not answered");
    chk_busy_ready: assert property (BVALID |-> !AWREADY && !WREADY)
        else $error("ready high while response pending");
    chk_b_release: assert property (BVALID && BREADY |=> !BVALID)
        else $error("write response not released");
    chk_r_release: assert property (RVALID && RREADY |=> !RVALID)
        else $error("read data not released");
    chk_rdata_width: assert property (RVALID |-> RDATA[31:16] == 16'h0000)
        else $error("read data above 16 bits");
    // ==========================================================
    // serial side
    chk_irq_pulse: assert property (CLOCKED_CHANNEL_IRQ |=> !CLOCKED_CHANNEL_IRQ)
        else $error("irq longer than one cycle");
    chk_rate_limit: assert property (FIRST_CLOCKED == 0 && $changed(SCK_OUT) |=> $stable(SCK_OUT))
        else $error("serial clock above a quarter of system clock");
    chk_data_leads: assert property ($changed(SO_OUT) && $stable(SCK_OUT) |-> ##[1:1000] $changed(SCK_OUT))
        else $error("early data not followed by clock");
    cover property (CLOCKED_CHANNEL_IRQ);
    cover property (BVALID && BRESP == `RESP_SLVERR);
    cover property ($changed(SCK_OUT));
endmodule // csi_master_chk
bind csi_master csi_master_chk #(.FIRST_CLOCKED(FIRST_CLOCKED)) i_csi_master_chk (
    .SYS_CLK(SYS_CLK), .RST(RST), .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID),
    .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY), .SCK_OUT(SCK_OUT),
    .SO_OUT(SO_OUT), .CLOCKED_CHANNEL_IRQ(CLOCKED_CHANNEL_IRQ));

// >>> tb_top.sv
// self-checking bench for the clocked serial master channel
`include "csi_map.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        SYS_CLK, RST, CE, AWVALID, WVALID, BREADY, ARVALID, RREADY, en;
    logic [7:0]  AWADDR, ARADDR, ctl, stx;
    logic [31:0] WDATA, rdat;
    logic [3:0]  WSTRB;
    logic [1:0]  resp;
    wire         AWREADY, WREADY, BVALID, ARREADY, RVALID, SCK_OUT, SO_OUT, SI_IN, IRQ;
    wire  [1:0]  BRESP, RRESP;
    wire  [31:0] RDATA;
    wire  [7:0]  srx;
    int          num_errors = 0, compares = 0, irq_cnt = 0;
    // ==========================================================
    // design and far side
    csi_master #(.FIRST_CLOCKED(0)) i_csi_master (.SYS_CLK(SYS_CLK), .RST(RST), .CE(CE),
        .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
        .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
        .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
        .RVALID(RVALID), .RREADY(RREADY), .SI_IN(SI_IN), .SCK_OUT(SCK_OUT), .SO_OUT(SO_OUT),
        .CLOCKED_CHANNEL_IRQ(IRQ));
    csi_slave_model i_csi_slave_model (.sck(SCK_OUT), .so(SO_OUT), .si(SI_IN), .en(en),
        .ckp(ctl[3]), .dap(ctl[2]), .lsb(ctl[4]), .nbits(ctl[1:0] == 2'b10 ? 4'd7 : 4'd8),
        .tx(stx), .rx(srx));
    initial begin
        SYS_CLK = 1'b0;
        forever #25 SYS_CLK = ~SYS_CLK;
    end
    always @(posedge SYS_CLK) if (IRQ === 1'b1) irq_cnt <= irq_cnt + 1;
    // ==========================================================
    // shared tasks
    task report_and_stop;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task tmo;
        num_errors++;
        $display("Error wait expected done seen timeout");
        report_and_stop;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d, input [3:0] s);
        int i;
        AWADDR <= a; WDATA <= d; WSTRB <= s; AWVALID <= 1'b1; WVALID <= 1'b1; BREADY <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge SYS_CLK);
            if (AWREADY === 1'b1) AWVALID <= 1'b0;
            if (WREADY === 1'b1) WVALID <= 1'b0;
            if (BVALID === 1'b1) break;
        end
        if (i == 50) tmo;
        resp = BRESP;
        BREADY <= 1'b0;
        @(posedge SYS_CLK);
    endtask
    task rd(input [7:0] a);
        int i;
        ARADDR <= a; ARVALID <= 1'b1; RREADY <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge SYS_CLK);
            if (ARREADY === 1'b1) ARVALID <= 1'b0;
            if (RVALID === 1'b1) break;
        end
        if (i == 50) tmo;
        rdat = RDATA; resp = RRESP;
        RREADY <= 1'b0;
        @(posedge SYS_CLK);
    endtask
    task wait_irq(input int tgt, output int n);
        for (n = 0; n < 2000 && irq_cnt < tgt; n++) @(posedge SYS_CLK);
        if (n == 2000) tmo;
    endtask
    // single transfer; tt is the frame length in system clocks
    task xfer(input [7:0] c, input [6:0] dv, input [7:0] t, input [7:0] s, input int tt);
        int n;
        wr(`OFS_DATA, {16'h0, dv, 1'b0, t}, 4'h3);
        ctl <= c; stx <= s;
        wr(`OFS_CTRL, {24'h0, c & 8'hBF}, 4'hF);
        en <= 1'b1;
        wr(`OFS_CTRL, {24'h0, c}, 4'hF);
        wait_irq(irq_cnt + 1, n);
        chk("frame cycles", 1, n >= tt - 3 && n <= tt + 3);
        en <= 1'b0;
        wr(`OFS_CTRL, {24'h0, c & 8'hBF}, 4'hF);
        chk("slave rx", c[1:0] == 2'b10 ? t & 8'h7F : t, srx);
    endtask
    // ==========================================================
    // scenarios
    task t_reset;
        rd(`OFS_DATA); chk("data reset", 32'h0, rdat);
        rd(`OFS_CTRL); chk("ctrl reset", 32'h003, rdat);
        rd(`OFS_STAT); chk("stat reset", 32'h0, rdat);
        rd(8'h0C); chk("unmapped resp", `RESP_SLVERR, resp);
        $display("t_reset done");
    endtask
    task t_data_reg;
        wr(`OFS_DATA, 32'hFE5A, 4'h3); rd(`OFS_DATA); chk("word", 32'hFE5A, rdat);
        wr(`OFS_DATA, 32'h773C, 4'h1); rd(`OFS_DATA); chk("alias", 32'h3C, rdat);
        rd(`OFS_STAT); chk("tx queued", 1, rdat[`ST_BUFFULL]);
        wr(`OFS_CTRL, 32'h1, 4'hF); rd(`OFS_CTRL); chk("nine bit", 32'h003, rdat);
        $display("t_data_reg done");
    endtask
    task t_msb8;
        xfer(8'h43, 7'd3, 8'hA5, 8'h3C, 64);
        rd(`OFS_DATA); chk("rx word", 32'h063C, rdat);
        $display("t_msb8 done");
    endtask
    task t_lsb7;
        xfer(8'h5E, 7'd3, 8'hD3, 8'hFF, 60);
        chk("sck idle", 1, SCK_OUT);
        rd(`OFS_DATA); chk("rx 7 bit", 32'h067F, rdat);
        $display("t_lsb7 done");
    endtask
    task t_fast;
        xfer(8'h43, 7'd0, 8'h96, 8'h69, 32);
        rd(`OFS_DATA); chk("fast upper", 32'h0, rdat[31:8]);
        $display("t_fast done");
    endtask
    task t_ovr;
        xfer(8'h43, 7'd3, 8'h11, 8'h22, 64);
        xfer(8'h43, 7'd3, 8'h33, 8'h44, 64);
        rd(`OFS_STAT); chk("overrun set", 1, rdat[`ST_OVF]);
        wr(`OFS_STAT, 32'h1, 4'hF); rd(`OFS_STAT); chk("overrun clear", 0, rdat[`ST_OVF]);
        rd(`OFS_DATA); chk("ovr word", 32'h0644, rdat);
        $display("t_ovr done");
    endtask
    task t_cont;
        int k, n, i;
        wr(`OFS_DATA, 32'h065A, 4'h3);
        ctl <= 8'h63; stx <= 8'h81;
        wr(`OFS_CTRL, 32'h23, 4'hF);
        en <= 1'b1;
        k = irq_cnt;
        wr(`OFS_CTRL, 32'h63, 4'hF);
        wait_irq(k + 1, n);
        wr(`OFS_DATA, 32'h0681, 4'h3);
        wait_irq(k + 2, n);
        for (i = 0; i < 100; i++) begin
            rd(`OFS_STAT);
            if (rdat[`ST_BUSY] === 1'b0) break;
        end
        if (i == 100) tmo;
        chk("slave rx", 8'h81, srx);
        chk("empty irqs", k + 2, irq_cnt);
        en <= 1'b0;
        wr(`OFS_CTRL, 32'h23, 4'hF);
        rd(`OFS_DATA); chk("cont word", 32'h0681, rdat);
        $display("t_cont done");
    endtask
    initial begin
        RST = 1'b1; CE = 1'b1; AWADDR = 8'h00; ARADDR = 8'h00; WDATA = 32'h0; WSTRB = 4'h0;
        AWVALID = 1'b0; WVALID = 1'b0; BREADY = 1'b0; ARVALID = 1'b0; RREADY = 1'b0;
        en = 1'b0; ctl = 8'h03; stx = 8'h00;
        repeat (2) @(posedge SYS_CLK);
        RST <= 1'b0;
        @(posedge SYS_CLK);
        t_reset;
        t_data_reg;
        t_msb8;
        t_lsb7;
        t_fast;
        t_ovr;
        t_cont;
        report_and_stop;
    end
endmodule // tb_top
